// [rphb_buf_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================
// buffer ram as firmware sees it
module rphb_buf_model (
  input wire logic        mclk_i,
  input wire logic        buf_wr_i,
  input wire logic [10:0] buf_addr_i,
  input wire logic [7:0]  buf_data_i,
  input wire logic        buf_wr_dma_i
);
  logic [7:0] mem [0:2047];
  logic       dma [0:2047];
  // store by record offset; writer kind kept per byte
  always_ff @(posedge mclk_i) begin
    if (buf_wr_i) begin
      mem[buf_addr_i] <= buf_data_i;
      dma[buf_addr_i] <= buf_wr_dma_i;
    end
  end
endmodule
`default_nettype wire

// [rphb_header_builder.sv]
`timescale 1ns/100ps
`default_nettype none

module rphb_header_builder #(
  parameter int unsigned MAX_PAYLOAD = rphb_pkg::MAX_PAYLOAD_DEF,
  parameter int unsigned NUM_EP      = rphb_pkg::NUM_EP_DEF
) (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       pkt_start_i,
  input  wire logic [3:0]                 pkt_endpoint_i,
  input  wire logic [3:0]                 pkt_pid_i,
  input  wire logic [6:0]                 matched_function_address_i,
  input  wire logic [15:0]                frame_count_i,
  input  wire logic                       pkt_toggle_i,
  input  wire logic                       rx_valid_i,
  input  wire logic [7:0]                 rx_data_i,
  input  wire logic                       pkt_end_i,
  input  wire logic                       crc_bad_i,
  output logic                            buf_wr_o,
  output logic [rphb_pkg::REC_AW-1:0]     buf_addr_o,
  output logic [7:0]                      buf_data_o,
  output logic                            buf_wr_dma_o,
  output logic                            record_done_o,
  output logic                            busy_o
);
  import rphb_pkg::*;

  // =====================================================================
  // state and captured packet fields
  rphb_state_t         state_reg, state_next;
  logic [3:0]          ep_reg;
  logic [3:0]          pid_reg;
  logic [6:0]          addr_reg;
  logic [15:0]         frame_reg;
  logic                tog_reg;
  logic                mismatch_reg;
  logic                crc_reg;
  logic [REC_AW-1:0]   count_reg;
  logic [2:0]          hdr_idx_reg;
  logic [NUM_EP-1:0]   prev_tog_reg;

  logic                wr_reg;
  logic [REC_AW-1:0]   addr_out_reg;
  logic [7:0]          data_out_reg;
  logic                dma_reg;
  logic                done_reg;

  // =====================================================================
  // decoding
  wire logic          take_start;
  wire logic          take_byte;
  wire logic          take_end;
  wire logic          room_left;
  wire logic          prev_tog_sel;
  wire logic          mismatch_now;
  wire logic [REC_AW-1:0] byte_count;
  wire logic [REC_AW-1:0] payload_addr;
  wire logic [7:0]    byte0;
  wire logic [7:0]    byte1;
  wire logic [7:0]    byte2;
  wire logic [7:0]    hdr_byte;
  wire logic          hdr_by_dma;
  wire logic [3:0]    ep_idx;

  // a new packet is only taken while idle; the caller watches busy_o
  assign take_start = (state_reg == ST_IDLE) && pkt_start_i;
  // a byte that arrives with the end strobe is dropped and must not be counted
  assign take_byte  = (state_reg == ST_PAYLOAD) && rx_valid_i && room_left
                      && !pkt_end_i;
  assign take_end   = (state_reg == ST_PAYLOAD) && pkt_end_i;

  // bytes past the buffer limit are dropped so the count stays honest
  assign room_left = (count_reg < REC_AW'(MAX_PAYLOAD));

  // toggle compare against the last toggle seen on this endpoint
  assign ep_idx       = pkt_endpoint_i;
  assign prev_tog_sel = prev_tog_reg[ep_idx];
  assign mismatch_now = (prev_tog_sel == pkt_toggle_i);

  // payload lands after the eight header bytes
  assign payload_addr = OFS_PAYLOAD + count_reg;
  assign byte_count   = count_reg + HDR_LEN;

  // header byte assembly
  assign byte0 = {crc_reg,
                  tog_reg,
                  mismatch_reg,
                  1'h0,
                  ep_reg};
  assign byte1 = {4'h0, pid_reg};
  assign byte2 = {1'h0, addr_reg};

  assign hdr_byte = (hdr_idx_reg == 3'h0) ? byte0 :
                    (hdr_idx_reg == 3'h1) ? byte1 :
                    (hdr_idx_reg == 3'h2) ? byte2 :
                    (hdr_idx_reg == 3'h3) ? 8'h00 :
                    (hdr_idx_reg == 3'h4) ? frame_reg[7:0] :
                    (hdr_idx_reg == 3'h5) ? frame_reg[15:8] :
                    (hdr_idx_reg == 3'h6) ? byte_count[7:0] :
                    {5'h00, byte_count[10:8]};

  // bytes six and seven belong to the buffer dma side
  assign hdr_by_dma = (hdr_idx_reg > HDR_SE_LAST);

  // =====================================================================
  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (pkt_start_i) begin
          state_next = ST_PAYLOAD;
        end
      end
      ST_PAYLOAD: begin
        if (pkt_end_i) begin
          state_next = ST_HEADER;
        end
      end
      ST_HEADER: begin
        if (hdr_idx_reg == HDR_LAST) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // =====================================================================
  // state register
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // =====================================================================
  // capture of per-packet fields at start
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ep_reg       <= 4'h0;
      pid_reg      <= 4'h0;
      addr_reg     <= 7'h00;
      frame_reg    <= 16'h0000;
      tog_reg      <= 1'h0;
      mismatch_reg <= 1'h0;
    end else if (take_start) begin
      ep_reg       <= pkt_endpoint_i;
      pid_reg      <= pkt_pid_i;
      addr_reg     <= matched_function_address_i;
      frame_reg    <= frame_count_i;
      tog_reg      <= pkt_toggle_i;
      mismatch_reg <= mismatch_now;
    end
  end

  // =====================================================================
  // previous toggle per endpoint; packet is stored even on mismatch
  // reset to one so a first data0 after reset is not flagged
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      prev_tog_reg <= {NUM_EP{PREV_TOG_RST}};
    end else if (take_start) begin
      prev_tog_reg[ep_idx] <= pkt_toggle_i;
    end
  end

  // =====================================================================
  // crc status, taken with the end of packet
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      crc_reg <= 1'h0;
    end else if (take_start) begin
      crc_reg <= 1'h0;
    end else if (take_end) begin
      crc_reg <= crc_bad_i;
    end
  end

  // =====================================================================
  // payload byte counter and header index
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      count_reg   <= '0;
      hdr_idx_reg <= 3'h0;
    end else begin
      if (take_start) begin
        count_reg <= '0;
      end else if (take_byte) begin
        count_reg <= count_reg + REC_AW'(1);
      end
      if (state_reg == ST_HEADER) begin
        hdr_idx_reg <= hdr_idx_reg + 3'h1;
      end else begin
        hdr_idx_reg <= 3'h0;
      end
    end
  end

  // =====================================================================
  // buffer write port; header goes last since crc is known only at end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      wr_reg       <= 1'h0;
      addr_out_reg <= '0;
      data_out_reg <= 8'h00;
      dma_reg      <= 1'h0;
      done_reg     <= 1'h0;
    end else begin
      wr_reg   <= 1'h0;
      dma_reg  <= 1'h0;
      done_reg <= 1'h0;
      if (take_byte && !take_end) begin
        wr_reg       <= 1'h1;
        addr_out_reg <= payload_addr;
        data_out_reg <= rx_data_i;
      end else if (state_reg == ST_HEADER) begin
        wr_reg       <= 1'h1;
        addr_out_reg <= OFS_BYTE0 + {8'h00, hdr_idx_reg};
        data_out_reg <= hdr_byte;
        dma_reg      <= hdr_by_dma;
        done_reg     <= (hdr_idx_reg == HDR_LAST);
      end
    end
  end

  // =====================================================================
  // outputs
  assign buf_wr_o      = wr_reg;
  assign buf_addr_o    = addr_out_reg;
  assign buf_data_o    = data_out_reg;
  assign buf_wr_dma_o  = dma_reg;
  assign record_done_o = done_reg;
  assign busy_o        = (state_reg != ST_IDLE);

endmodule

`default_nettype wire

// [rphb_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================
// record write checker
module rphb_monitor (
  input wire logic                        mclk_i,
  input wire logic                        rst_b_i,
  input wire logic                        rx_valid_i,
  input wire logic [7:0]                  rx_data_i,
  input wire logic                        pkt_end_i,
  input wire logic                        crc_bad_i,
  input wire logic                        buf_wr_o,
  input wire logic [rphb_pkg::REC_AW-1:0] buf_addr_o,
  input wire logic [7:0]                  buf_data_o,
  input wire logic                        buf_wr_dma_o,
  input wire logic                        record_done_o,
  input wire logic                        busy_o
);
  import rphb_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // header writes come as one burst
  AST_HDR_ORDER: assert property (buf_wr_o && buf_addr_o == 11'h000 |=>
    buf_wr_o && buf_addr_o == 11'h001) else $error("header order broken");
  AST_PAYLOAD: assert property (buf_wr_o && buf_addr_o >= OFS_PAYLOAD |->
    $past(rx_valid_i) && buf_data_o == $past(rx_data_i)) else $error("payload byte wrong");
  AST_SE_BYTES: assert property (buf_wr_o && buf_addr_o <= 11'h005 |->
    !buf_wr_dma_o) else $error("engine byte marked dma");
  AST_DMA_BYTES: assert property (buf_wr_dma_o |->
    buf_wr_o && buf_addr_o[10:1] == 10'h003) else $error("dma byte misplaced");
  AST_CRC: assert property (pkt_end_i && busy_o |-> ##2 buf_wr_o &&
    buf_addr_o == 11'h000 && buf_data_o[BIT_CRC_ERR] == $past(crc_bad_i, 2))
    else $error("crc flag wrong");
  AST_BYTE0_ZERO: assert property (buf_wr_o && buf_addr_o == 11'h000 |->
    !buf_data_o[4]) else $error("byte zero bit four set");
  AST_BYTE1_HI: assert property (buf_wr_o && buf_addr_o == 11'h001 |->
    buf_data_o[7:4] == 4'h0) else $error("pid upper bits set");
  AST_CNT_HI: assert property (buf_wr_o && buf_addr_o == 11'h007 |->
    buf_data_o[7:3] == 5'h00 && record_done_o) else $error("count high byte wrong");
endmodule
bind rphb_header_builder rphb_monitor mon_u (.mclk_i, .rst_b_i, .rx_valid_i, .rx_data_i,
  .pkt_end_i, .crc_bad_i, .buf_wr_o, .buf_addr_o, .buf_data_o, .buf_wr_dma_o,
  .record_done_o, .busy_o);
`default_nettype wire

// [rphb_pkg.sv]
// Overview of operation
// - record offsets zero to seven are reserved for the header, ahead of payload.
// - payload bytes are stored in order from offset 8 to size plus seven.
// - stored byte count equals payload size plus eight.
// - serial bus engine writes header bytes zero through five.
// - engine buffer dma writes header bytes six and seven, the byte count.
// - toggle mismatch flag set when current toggle equals previous toggle.
// - byte zero records the toggle of the most recently received packet.
// - crc error flag set in byte zero when received crc is invalid.
package rphb_pkg;

  // =====================================================================
  // record layout
  localparam int unsigned REC_AW      = 11;
  localparam logic [10:0] OFS_BYTE0   = 11'h000;
  localparam logic [10:0] OFS_PAYLOAD = 11'h008;
  localparam logic [2:0]  HDR_LAST    = 3'h7;
  localparam logic [2:0]  HDR_SE_LAST = 3'h5;
  localparam logic [10:0] HDR_LEN     = 11'h008;

  // =====================================================================
  // header byte zero field positions
  localparam int unsigned BIT_CRC_ERR  = 7;
  localparam int unsigned BIT_PREV_TOG = 6;
  localparam int unsigned BIT_MISMATCH = 5;

  // =====================================================================
  // reset values and limits
  localparam logic        PREV_TOG_RST    = 1'h1;
  localparam int unsigned MAX_PAYLOAD_DEF = 1280;
  localparam int unsigned NUM_EP_DEF      = 16;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PAYLOAD,
    ST_HEADER
  } rphb_state_t;

endpackage

// [rx_packet_header_builder_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================
// bench
module rx_packet_header_builder_tb_top;
  import rphb_pkg::*;
  logic              mclk_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic              start = 1'b0, tog = 1'b0, rxv = 1'b0, pe = 1'b0, crcb = 1'b0;
  logic [3:0]        ep = 4'h0;
  logic [7:0]        rxd = 8'h00;
  logic [15:0]       frame = 16'h0000;
  logic              wr, dma, done, busy;
  logic [REC_AW-1:0] addr;
  logic [7:0]        data;
  int                err_count = 0, checked = 0, cyc = 0;
  always #25 mclk_i = ~mclk_i;
  rphb_header_builder dut_u (.mclk_i, .rst_b_i, .pkt_start_i(start), .pkt_endpoint_i(ep),
    .pkt_pid_i(~ep), .matched_function_address_i({3'h5, ep}), .frame_count_i(frame),
    .pkt_toggle_i(tog), .rx_valid_i(rxv), .rx_data_i(rxd), .pkt_end_i(pe),
    .crc_bad_i(crcb), .buf_wr_o(wr), .buf_addr_o(addr), .buf_data_o(data),
    .buf_wr_dma_o(dma), .record_done_o(done), .busy_o(busy));
  rphb_buf_model buf_u (.mclk_i, .buf_wr_i(wr), .buf_addr_i(addr), .buf_data_i(data),
    .buf_wr_dma_i(dma));
  task automatic final_report();
    $display("mismatches=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above four packets of up to 300 bytes
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // payload depends on size so stale ram never matches
  function automatic logic [7:0] pat(input int k, input int n);
    return 8'(k) ^ 8'(n) ^ 8'h5a;
  endfunction
  // one packet; a second start mid-payload must be ignored
  // tl puts one extra byte beside the end strobe; it must be dropped, not counted
  task automatic run(input logic [3:0] e, input logic t, c, mm, input int n, input logic tl);
    int k;
    logic [10:0] cnt;
    cnt = 11'(n) + 11'h008;
    @(posedge mclk_i);
    start <= 1'b1; ep <= e; tog <= t; frame <= 16'h8100 + 16'(n);
    for (k = 0; k < n; k++) begin
      @(posedge mclk_i);
      start <= (k == 1); rxv <= 1'b1; rxd <= pat(k, n);
      if (k == 1) ep <= ~e;
    end
    @(posedge mclk_i);
    start <= 1'b0; rxv <= tl; rxd <= 8'hee; pe <= 1'b1; crcb <= c;
    @(posedge mclk_i);
    rxv <= 1'b0; pe <= 1'b0; crcb <= 1'b0;
    @(negedge mclk_i);
    cmp({7'h00, busy}, 8'h01);
    k = 0;
    do begin @(negedge mclk_i); k++; end while (done !== 1'b1 && k < 20);
    @(posedge mclk_i);
    #1;
    cmp({7'h00, busy}, 8'h00);
    cmp(buf_u.mem[0], {c, t, mm, 1'b0, e});
    cmp(buf_u.mem[1], {4'h0, ~e});
    cmp(buf_u.mem[2], {4'h5, e});
    cmp(buf_u.mem[3], 8'h00);
    cmp(buf_u.mem[4], frame[7:0]);
    cmp(buf_u.mem[5], frame[15:8]);
    cmp(buf_u.mem[6], cnt[7:0]);
    cmp(buf_u.mem[7], {5'h00, cnt[10:8]});
    cmp({5'h00, buf_u.dma[7], buf_u.dma[6], buf_u.dma[5]}, 8'h06);
    for (k = 0; k < n; k++) cmp(buf_u.mem[8 + k], pat(k, n));
  endtask
  // toggle table: reset value 1, then 0,0 / 1,1 / 0,1
  task automatic s_first();
    run(4'h3, 1'b0, 1'b0, 1'b0, 4, 1'b0);
  endtask
  task automatic s_repeat();
    run(4'h3, 1'b0, 1'b1, 1'b1, 0, 1'b0);
  endtask
  task automatic s_other();
    run(4'h5, 1'b1, 1'b0, 1'b1, 300, 1'b0);
  endtask
  task automatic s_flip();
    run(4'h3, 1'b1, 1'b0, 1'b0, 1, 1'b1);
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    s_first();
    s_repeat();
    s_other();
    s_flip();
    final_report();
  end
endmodule
`default_nettype wire
